// [include/sba_regs.svh]
`ifndef SBA_REGS_SVH
`define SBA_REGS_SVH
// address lines, transfer fields
`define SBA_ADDR_MSB 35
`define SBA_ADDR_LSB 3
`define SBA_ADDR_W 33
`define SBA_BIT20_POS 20
`define SBA_STB0_MSB 16
`define SBA_STB1_LSB 17
`define SBA_REQ_W 5
`define SBA_STB_W 2
// power-on strap field on the address lines
`define SBA_CFG_MSB 31
`define SBA_CFG_LSB 27
`define SBA_CFG_W 5
// timing
`define SBA_CLK_PERIOD_NS 10
`define SBA_BCLK_PERIOD_NS 125
`define SBA_BCLK_HALF_CYC ((`SBA_BCLK_PERIOD_NS / `SBA_CLK_PERIOD_NS) / 2)
`define SBA_STB_SETUP_CYC 4'h2
`define SBA_STB_PH2_CYC 4'h4
`define SBA_STRAP_HOLD_CYC 6'h20
`endif

// [include/sba_pkg.sv]
`include "sba_regs.svh"
package sba_pkg;
  typedef logic [`SBA_ADDR_MSB:`SBA_ADDR_LSB] sba_addr_t;
  typedef logic [`SBA_REQ_W-1:0]              sba_req_t;
  typedef enum logic [1:0] {
    SBA_TX_IDLE = 2'b00,
    SBA_TX_PH1  = 2'b01,
    SBA_TX_PH2  = 2'b10,
    SBA_TX_HOLD = 2'b11
  } sba_tx_st_t;
endpackage

// [include/sba_bus_if.sv]
`timescale 1ns/10ps
`include "sba_regs.svh"
interface sba_bus_if;
  // common-clock lines made by the agent end
  logic                             bus_clock_true_phase;
  logic                             bus_reset_n;
  logic                             addr_bit20_mask_in_n;
  // driver halves
  sba_pkg::sba_addr_t               dev_addr_out;
  sba_pkg::sba_req_t                dev_req_out;
  logic                             dev_avs_out;
  logic [`SBA_STB_W-1:0]            dev_stb_out;
  logic                             dev_drv_oe;
  logic                             dev_stall_out;
  logic                             dev_stall_oe;
  sba_pkg::sba_addr_t               agt_addr_out;
  logic                             agt_addr_oe;
  logic                             agt_stall_out;
  logic                             agt_stall_oe;
  // resolved wire levels, pulled high when nobody drives
  sba_pkg::sba_addr_t               addr_n;
  sba_pkg::sba_req_t                req_type_n;
  logic                             addr_valid_strobe_n;
  logic [`SBA_STB_W-1:0]            src_sync_addr_strobes_n;
  logic                             block_next_request_n;

  assign addr_n = (dev_addr_out | ~{`SBA_ADDR_W{dev_drv_oe}}) & (agt_addr_out | ~{`SBA_ADDR_W{agt_addr_oe}});
  assign req_type_n = dev_req_out | ~{`SBA_REQ_W{dev_drv_oe}};
  assign addr_valid_strobe_n = dev_avs_out | ~dev_drv_oe;
  assign src_sync_addr_strobes_n = dev_stb_out | ~{`SBA_STB_W{dev_drv_oe}};
  assign block_next_request_n = (dev_stall_out | ~dev_stall_oe) & (agt_stall_out | ~agt_stall_oe);

  modport dev (
    input  bus_clock_true_phase, bus_reset_n, addr_bit20_mask_in_n,
    input  addr_n, addr_valid_strobe_n, block_next_request_n,
    output dev_addr_out, dev_req_out, dev_avs_out, dev_stb_out, dev_drv_oe, dev_stall_out, dev_stall_oe
  );
  modport agt (
    output bus_clock_true_phase, bus_reset_n, addr_bit20_mask_in_n,
    output agt_addr_out, agt_addr_oe, agt_stall_out, agt_stall_oe,
    input  addr_n, req_type_n, addr_valid_strobe_n, src_sync_addr_strobes_n, block_next_request_n
  );
endinterface

// [design/sba_dev_end.sv]
// How it works
// - address first, then transaction type, same lines
// - address lines carry bits 35 down to 3
// - receivers capture address with strobes, not clock
// - sample power-on straps when bus reset releases
// - mask forces address bit 20 low
// - mask only in real mode, arrives asynchronously
// - valid strobe marks address and request lines valid
// - every agent watches valid strobe, starts decode
// - capture on both strobe edges
// - request lines and bits 16..3 use strobe zero
// - common-clock signals timed from bus clock rise
// - agent unable to accept asserts block-next-request
// - no new transaction while bus is stalled
`timescale 1ns/10ps
`include "sba_regs.svh"
module sba_dev_end (
  // system
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  // bus pins
  sba_bus_if.dev                           bus,
  // request side
  input  wire logic                        i_req_valid,
  input  wire sba_pkg::sba_addr_t          i_addr,
  input  wire sba_pkg::sba_req_t           i_ph1_req,
  input  wire sba_pkg::sba_addr_t          i_ph2_info,
  input  wire sba_pkg::sba_req_t           i_ph2_req,
  output logic                             o_req_taken,
  // local status
  input  wire logic                        i_busy,
  output sba_pkg::sba_addr_t               o_lookup_addr,
  output logic [`SBA_CFG_W-1:0]            o_pwron_cfg,
  output logic                             o_snoop_start
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic                        bclk_s1;
    logic                        bclk_s2;
    logic                        bclk_q;
    logic                        rstn_s1;
    logic                        rstn_s2;
    logic                        rstn_q;
    logic                        a20n_s1;
    logic                        a20n_s2;
    logic                        avs_s1;
    logic                        avs_s2;
    logic                        stall_s1;
    logic                        stall_s2;
    logic [`SBA_CFG_W-1:0]       cfg_s1;
    logic [`SBA_CFG_W-1:0]       cfg_s2;
    sba_pkg::sba_tx_st_t         st;
    logic [3:0]                  cnt;
    logic                        drv_oe;
    sba_pkg::sba_addr_t          a_out;
    sba_pkg::sba_req_t           req_out;
    logic                        avs_out;
    logic [`SBA_STB_W-1:0]       stb_out;
    sba_pkg::sba_addr_t          ph2_info;
    sba_pkg::sba_req_t           ph2_req;
    logic                        stall_oe;
    logic [`SBA_CFG_W-1:0]       cfg;
    sba_pkg::sba_addr_t          lookup;
    logic                        taken;
    logic                        snoop;
  } sba_dev_state_t;

  sba_dev_state_t     st_reg;
  sba_dev_state_t     st_next;
  logic               bclk_rise;
  sba_pkg::sba_addr_t masked;

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    st_next = st_reg;
    bclk_rise = st_reg.bclk_s2 & ~st_reg.bclk_q;
    masked = i_addr;
    if (!st_reg.a20n_s2) begin
      masked[`SBA_BIT20_POS] = 1'b0;
    end

    // every pin input goes through two flops first
    st_next.bclk_s1 = bus.bus_clock_true_phase;
    st_next.bclk_s2 = st_reg.bclk_s1;
    st_next.bclk_q  = st_reg.bclk_s2;
    st_next.rstn_s1 = bus.bus_reset_n;
    st_next.rstn_s2 = st_reg.rstn_s1;
    st_next.rstn_q  = st_reg.rstn_s2;
    st_next.a20n_s1 = bus.addr_bit20_mask_in_n;
    st_next.a20n_s2 = st_reg.a20n_s1;
    st_next.avs_s1   = bus.addr_valid_strobe_n;
    st_next.avs_s2   = st_reg.avs_s1;
    st_next.stall_s1 = bus.block_next_request_n;
    st_next.stall_s2 = st_reg.stall_s1;
    st_next.cfg_s1  = bus.addr_n[`SBA_CFG_MSB:`SBA_CFG_LSB];
    st_next.cfg_s2  = st_reg.cfg_s1;

    st_next.taken  = 1'b0;
    st_next.snoop  = 1'b0;
    st_next.lookup = masked;
    st_next.stall_oe = i_busy;

    if (st_reg.rstn_s2 && !st_reg.rstn_q) begin
      st_next.cfg = ~st_reg.cfg_s2;
    end

    if (bclk_rise && !st_reg.avs_s2 && !st_reg.drv_oe) begin
      st_next.snoop = 1'b1;
    end

    case (st_reg.st)
      sba_pkg::SBA_TX_IDLE: begin
        if (bclk_rise && i_req_valid && st_reg.stall_s2 && st_reg.rstn_s2) begin
          st_next.drv_oe   = 1'b1;
          st_next.a_out    = ~masked;
          st_next.req_out  = ~i_ph1_req;
          st_next.avs_out  = 1'b0;
          st_next.stb_out  = '1;
          st_next.ph2_info = i_ph2_info;
          st_next.ph2_req  = i_ph2_req;
          st_next.cnt      = `SBA_STB_SETUP_CYC;
          st_next.taken    = 1'b1;
          st_next.st       = sba_pkg::SBA_TX_PH1;
        end
      end
      sba_pkg::SBA_TX_PH1: begin
        if (st_reg.cnt == 4'h0) begin
          // strobe zero moves with strobe one
          st_next.stb_out = '0;
          st_next.cnt     = `SBA_STB_PH2_CYC;
          st_next.st      = sba_pkg::SBA_TX_PH2;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      sba_pkg::SBA_TX_PH2: begin
        // data held past the fall, then swapped a setup time before the rise
        if (st_reg.cnt == `SBA_STB_SETUP_CYC) begin
          st_next.a_out   = ~st_reg.ph2_info;
          st_next.req_out = ~st_reg.ph2_req;
        end
        if (st_reg.cnt == 4'h0) begin
          st_next.stb_out = '1;
          st_next.st      = sba_pkg::SBA_TX_HOLD;
        end else begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
      end
      sba_pkg::SBA_TX_HOLD: begin
        // valid strobe released on the next rise
        if (bclk_rise) begin
          st_next.drv_oe  = 1'b0;
          st_next.avs_out = 1'b1;
          st_next.st      = sba_pkg::SBA_TX_IDLE;
        end
      end
      default: begin
        st_next.st = sba_pkg::SBA_TX_IDLE;
      end
    endcase

    // bus reset aborts any phase and frees the lines for straps
    if (!st_reg.rstn_s2) begin
      st_next.drv_oe  = 1'b0;
      st_next.avs_out = 1'b1;
      st_next.st      = sba_pkg::SBA_TX_IDLE;
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
      // synced pin copies start at the idle wire level, so no false edge follows reset
      st_reg.a20n_s1  <= 1'b1;
      st_reg.a20n_s2  <= 1'b1;
      st_reg.avs_s1   <= 1'b1;
      st_reg.avs_s2   <= 1'b1;
      st_reg.stall_s1 <= 1'b1;
      st_reg.stall_s2 <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign bus.dev_addr_out = st_reg.a_out;
  assign bus.dev_req_out  = st_reg.req_out;
  assign bus.dev_avs_out  = st_reg.avs_out;
  assign bus.dev_stb_out  = st_reg.stb_out;
  assign bus.dev_drv_oe   = st_reg.drv_oe;
  assign bus.dev_stall_out = 1'b0;
  assign bus.dev_stall_oe  = st_reg.stall_oe;
  assign o_req_taken      = st_reg.taken;
  assign o_lookup_addr    = st_reg.lookup;
  assign o_pwron_cfg      = st_reg.cfg;
  assign o_snoop_start    = st_reg.snoop;

endmodule

// [design/sba_agt_end.sv]
`timescale 1ns/10ps
`include "sba_regs.svh"
module sba_agt_end #(
  parameter int BCLK_HALF_CYC = `SBA_BCLK_HALF_CYC
) (
  // system
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  // bus pins
  sba_bus_if.agt                           bus,
  // control of the device
  input  wire logic                        i_bus_reset,
  input  wire logic [`SBA_CFG_W-1:0]       i_strap_cfg,
  input  wire logic                        i_bit20_mask,
  input  wire logic                        i_busy,
  // received transactions
  output logic                             o_decode_start,
  output logic                             o_rx_valid,
  output sba_pkg::sba_addr_t               o_rx_addr,
  output sba_pkg::sba_req_t                o_rx_req1,
  output sba_pkg::sba_addr_t               o_rx_info,
  output sba_pkg::sba_req_t                o_rx_req2
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [3:0]                  bcnt;
    logic                        bclk;
    logic                        rstn;
    logic                        a20n;
    logic [5:0]                  hold;
    logic                        strap_oe;
    sba_pkg::sba_addr_t          addr_out;
    logic                        stall_oe;
    sba_pkg::sba_addr_t          addr_s1;
    sba_pkg::sba_addr_t          addr_s2;
    sba_pkg::sba_req_t           req_s1;
    sba_pkg::sba_req_t           req_s2;
    logic [`SBA_STB_W-1:0]       stb_s1;
    logic [`SBA_STB_W-1:0]       stb_s2;
    logic [`SBA_STB_W-1:0]       stb_q;
    logic                        avs_s1;
    logic                        avs_s2;
    logic [`SBA_STB_W-1:0]       got;
    sba_pkg::sba_addr_t          rx_addr;
    sba_pkg::sba_req_t           rx_req1;
    sba_pkg::sba_addr_t          rx_info;
    sba_pkg::sba_req_t           rx_req2;
    logic                        rx_valid;
    logic                        dec_start;
  } sba_agt_state_t;

  localparam logic [3:0] HALF_LAST = 4'(BCLK_HALF_CYC - 1);

  sba_agt_state_t        st_reg;
  sba_agt_state_t        st_next;
  logic [`SBA_STB_W-1:0] stb_fall;
  logic [`SBA_STB_W-1:0] stb_rise;
  logic                  own_rise;

  for (genvar g = 0; g < `SBA_STB_W; g++) begin : g_stb
    assign stb_fall[g] = st_reg.stb_q[g] & ~st_reg.stb_s2[g];
    assign stb_rise[g] = ~st_reg.stb_q[g] & st_reg.stb_s2[g];
  end

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    st_next = st_reg;
    own_rise = (st_reg.bcnt == HALF_LAST) & ~st_reg.bclk;
    if (st_reg.bcnt == HALF_LAST) begin
      st_next.bcnt = 4'h0;
      st_next.bclk = ~st_reg.bclk;
    end else begin
      st_next.bcnt = st_reg.bcnt + 4'h1;
    end

    st_next.rstn   = ~i_bus_reset;
    st_next.a20n   = ~i_bit20_mask;
    st_next.stall_oe = i_busy;

    // straps held past release so the device sees them settle
    if (i_bus_reset) begin
      st_next.hold = `SBA_STRAP_HOLD_CYC;
    end else if (st_reg.hold != 6'h0) begin
      st_next.hold = st_reg.hold - 6'h1;
    end
    st_next.strap_oe = i_bus_reset | (st_reg.hold != 6'h0);
    st_next.addr_out = '1;
    st_next.addr_out[`SBA_CFG_MSB:`SBA_CFG_LSB] = ~i_strap_cfg;

    // strobe-timed capture, sampled through two flops
    st_next.addr_s1 = bus.addr_n;
    st_next.addr_s2 = st_reg.addr_s1;
    st_next.req_s1  = bus.req_type_n;
    st_next.req_s2  = st_reg.req_s1;
    st_next.stb_s1  = bus.src_sync_addr_strobes_n;
    st_next.stb_s2  = st_reg.stb_s1;
    st_next.stb_q   = st_reg.stb_s2;
    st_next.avs_s1  = bus.addr_valid_strobe_n;
    st_next.avs_s2  = st_reg.avs_s1;

    st_next.rx_valid  = 1'b0;
    // valid strobe sampled at bus clock rise
    st_next.dec_start = own_rise & ~st_reg.avs_s2;

    if (&st_reg.got) begin
      st_next.rx_valid = 1'b1;
      st_next.got      = '0;
    end
    // strobe zero carries request and low address
    if (stb_fall[0]) begin
      st_next.rx_req1 = ~st_reg.req_s2;
      st_next.rx_addr[`SBA_STB0_MSB:`SBA_ADDR_LSB] = ~st_reg.addr_s2[`SBA_STB0_MSB:`SBA_ADDR_LSB];
    end
    if (stb_rise[0]) begin
      st_next.rx_req2 = ~st_reg.req_s2;
      st_next.rx_info[`SBA_STB0_MSB:`SBA_ADDR_LSB] = ~st_reg.addr_s2[`SBA_STB0_MSB:`SBA_ADDR_LSB];
      st_next.got[0]  = 1'b1;
    end
    if (stb_fall[1]) begin
      st_next.rx_addr[`SBA_ADDR_MSB:`SBA_STB1_LSB] = ~st_reg.addr_s2[`SBA_ADDR_MSB:`SBA_STB1_LSB];
    end
    if (stb_rise[1]) begin
      st_next.rx_info[`SBA_ADDR_MSB:`SBA_STB1_LSB] = ~st_reg.addr_s2[`SBA_ADDR_MSB:`SBA_STB1_LSB];
      st_next.got[1] = 1'b1;
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg      <= '0;
      st_reg.a20n <= 1'b1;
      // synced strobe copies start high like the idle wires, avoiding a false capture
      st_reg.stb_s1 <= '1;
      st_reg.stb_s2 <= '1;
      st_reg.stb_q  <= '1;
      st_reg.avs_s1 <= 1'b1;
      st_reg.avs_s2 <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign bus.bus_clock_true_phase = st_reg.bclk;
  assign bus.bus_reset_n          = st_reg.rstn;
  assign bus.addr_bit20_mask_in_n = st_reg.a20n;
  assign bus.agt_addr_out         = st_reg.addr_out;
  assign bus.agt_addr_oe          = st_reg.strap_oe;
  assign bus.agt_stall_out        = 1'b0;
  assign bus.agt_stall_oe         = st_reg.stall_oe;
  assign o_decode_start           = st_reg.dec_start;
  assign o_rx_valid               = st_reg.rx_valid;
  assign o_rx_addr                = st_reg.rx_addr;
  assign o_rx_req1                = st_reg.rx_req1;
  assign o_rx_info                = st_reg.rx_info;
  assign o_rx_req2                = st_reg.rx_req2;

endmodule

// [tb/sba_bus_asserts.sv]
`timescale 1ns/10ps
module sba_bus_asserts (
  // system
  input wire logic               i_clk,
  input wire logic               i_sys_rst,
  // resolved wire levels
  input wire logic               bus_reset_n,
  input wire sba_pkg::sba_addr_t addr_n,
  input wire sba_pkg::sba_req_t  req_type_n,
  input wire logic               addr_valid_strobe_n,
  input wire logic [1:0]         src_sync_addr_strobes_n,
  input wire logic               block_next_request_n,
  // drive enables
  input wire logic               dev_drv_oe,
  input wire logic               agt_addr_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ****************************************
  // address phase wire checks
  // ****************************************
  AST_AVS_AT_START: assert property ($rose(dev_drv_oe) |-> !addr_valid_strobe_n)
    else $error("valid strobe not low when device starts driving");
  AST_STB_IDLE_AT_START: assert property ($rose(dev_drv_oe) |-> src_sync_addr_strobes_n == 2'b11)
    else $error("strobes not high at start of transfer");
  AST_STB_FALL: assert property ($rose(dev_drv_oe) |-> ##3 src_sync_addr_strobes_n == 2'b00)
    else $error("strobes did not fall three cycles after start");
  AST_PH1_HOLD: assert property ($fell(src_sync_addr_strobes_n[0]) |-> $stable(addr_n)[*2])
    else $error("phase one address moved around falling strobe");
  AST_STB_RISE: assert property ($fell(src_sync_addr_strobes_n[0]) |-> ##5 src_sync_addr_strobes_n == 2'b11)
    else $error("strobes did not rise five cycles after falling");
  AST_AVS_HELD: assert property ($fell(src_sync_addr_strobes_n[0]) |-> !addr_valid_strobe_n[*5])
    else $error("valid strobe released while strobes move");
  AST_STB_PAIRED: assert property (dev_drv_oe |-> src_sync_addr_strobes_n[0] == src_sync_addr_strobes_n[1])
    else $error("strobe zero and strobe one differ");
  AST_PH2_SETUP: assert property ($rose(src_sync_addr_strobes_n[0]) |-> $stable(addr_n) && $stable(req_type_n))
    else $error("phase two lines moved at rising strobe");
  AST_STALL_NO_START: assert property (!block_next_request_n[*4] |=> !$rose(dev_drv_oe))
    else $error("transfer started while bus stalled");
  AST_QUIET_IN_BUS_RESET: assert property (!bus_reset_n[*4] |-> !dev_drv_oe)
    else $error("device drives during bus reset");
  AST_STRAP_DRIVE: assert property ($rose(bus_reset_n) |-> agt_addr_oe[*8])
    else $error("straps dropped at bus reset release");
  AST_ONE_DRIVER: assert property (!(agt_addr_oe && dev_drv_oe))
    else $error("two drivers on address lines");
endmodule

// [tb/system_bus_address_phase_bench.sv]
`timescale 1ns/10ps
module system_bus_address_phase_bench;
  logic               i_clk;
  logic               i_sys_rst;
  logic               req_valid;
  sba_pkg::sba_addr_t req_addr;
  sba_pkg::sba_req_t  req_ph1;
  sba_pkg::sba_addr_t req_info;
  sba_pkg::sba_req_t  req_ph2;
  logic               req_taken;
  logic               dev_busy;
  sba_pkg::sba_addr_t lookup_addr;
  logic [4:0]         pwron_cfg;
  logic               snoop_start;
  logic               bus_reset;
  logic [4:0]         strap_cfg;
  logic               bit20_mask;
  logic               agt_busy;
  logic               decode_start;
  logic               rx_valid;
  sba_pkg::sba_addr_t rx_addr;
  sba_pkg::sba_req_t  rx_req1;
  sba_pkg::sba_addr_t rx_info;
  sba_pkg::sba_req_t  rx_req2;
  int                 fails;
  int                 comparisons;

  sba_bus_if bus ();
  sba_dev_end i_sba_dev_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus.dev), .i_req_valid(req_valid),
    .i_addr(req_addr), .i_ph1_req(req_ph1), .i_ph2_info(req_info), .i_ph2_req(req_ph2), .o_req_taken(req_taken),
    .i_busy(dev_busy), .o_lookup_addr(lookup_addr), .o_pwron_cfg(pwron_cfg), .o_snoop_start(snoop_start));
  sba_agt_end i_sba_agt_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus.agt), .i_bus_reset(bus_reset),
    .i_strap_cfg(strap_cfg), .i_bit20_mask(bit20_mask), .i_busy(agt_busy), .o_decode_start(decode_start),
    .o_rx_valid(rx_valid), .o_rx_addr(rx_addr), .o_rx_req1(rx_req1), .o_rx_info(rx_info), .o_rx_req2(rx_req2));
  sba_bus_asserts i_sba_bus_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus_reset_n(bus.bus_reset_n),
    .addr_n(bus.addr_n), .req_type_n(bus.req_type_n), .addr_valid_strobe_n(bus.addr_valid_strobe_n),
    .src_sync_addr_strobes_n(bus.src_sync_addr_strobes_n), .block_next_request_n(bus.block_next_request_n),
    .dev_drv_oe(bus.dev_drv_oe), .agt_addr_oe(bus.agt_addr_oe));

  always #5 i_clk = ~i_clk;

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    fails++;
    $display("unexpected timeout waiting for %s", what);
    close_out();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic strap_scenario(input logic [4:0] cfg);
    bus_reset = 1'b1;
    strap_cfg = cfg;
    step(10);
    check("strap wire", 64'(bus.addr_n[31:27]), 64'(5'(~cfg)));
    check("mask line idle", 64'(bus.addr_bit20_mask_in_n), 64'(1'b1));
    bus_reset = 1'b0;
    step(45);
    // later strap changes must not reach the sampled copy
    strap_cfg = ~cfg;
    step(3);
    check("pwron_cfg", 64'(pwron_cfg), 64'(cfg));
  endtask

  task automatic xfer(input sba_pkg::sba_addr_t a, input sba_pkg::sba_req_t r1,
                      input sba_pkg::sba_addr_t inf, input sba_pkg::sba_req_t r2, input logic stalled);
    sba_pkg::sba_addr_t exp_a;
    int n;
    int starts;
    int snoops;
    exp_a = a;
    exp_a[20] = a[20] & ~bit20_mask;
    starts = 0;
    snoops = 0;
    n = 0;
    req_addr = a;
    req_ph1 = r1;
    req_info = inf;
    req_ph2 = r2;
    req_valid = 1'b1;
    if (stalled) begin
      repeat (30) begin
        step(1);
        n += int'(req_taken === 1'b1);
      end
      check("taken while stalled", 64'(n), 64'(0));
      check("stall line", 64'(bus.block_next_request_n), 64'(1'b0));
      agt_busy = 1'b0;
      dev_busy = 1'b0;
    end
    n = 0;
    while (req_taken !== 1'b1) begin
      step(1);
      n++;
      if (n > 60) give_up("req_taken");
    end
    req_valid = 1'b0;
    check("lookup_addr", 64'(lookup_addr), 64'(exp_a));
    n = 0;
    while (rx_valid !== 1'b1) begin
      step(1);
      n++;
      starts += int'(decode_start === 1'b1);
      snoops += int'(snoop_start === 1'b1);
      if (n > 60) give_up("rx_valid");
    end
    check("rx_addr", 64'(rx_addr), 64'(exp_a));
    check("rx_req1", 64'(rx_req1), 64'(r1));
    check("rx_info", 64'(rx_info), 64'(inf));
    check("rx_req2", 64'(rx_req2), 64'(r2));
    n = 0;
    while (bus.dev_drv_oe !== 1'b0) begin
      step(1);
      n++;
      starts += int'(decode_start === 1'b1);
      snoops += int'(snoop_start === 1'b1);
      if (n > 60) give_up("bus release");
    end
    check("decode starts", 64'(starts), 64'(1));
    check("snoop on own transfer", 64'(snoops), 64'(0));
  endtask

  task automatic mask_scenario(input logic on);
    // mask only changes between transfers, never mid-transfer
    bit20_mask = on;
    step(10);
    check("mask wire", 64'(bus.addr_bit20_mask_in_n), 64'(!on));
    xfer(33'h1_FFFF_FFFF, 5'h1F, 33'h1_FFFF_FFFF, 5'h00, 1'b0);
  endtask

  task automatic stall_scenario(input logic by_device);
    agt_busy = ~by_device;
    dev_busy = by_device;
    step(4);
    xfer(33'h0_DEAD_BEEF, 5'h0C, 33'h1_2345_6789, 5'h13, 1'b1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    req_valid = 1'b0;
    req_addr = '0;
    req_ph1 = '0;
    req_info = '0;
    req_ph2 = '0;
    dev_busy = 1'b0;
    bus_reset = 1'b1;
    strap_cfg = 5'h15;
    bit20_mask = 1'b0;
    agt_busy = 1'b0;
    fails = 0;
    comparisons = 0;
    step(2);
    i_sys_rst = 1'b0;
    strap_scenario(5'h15);
    strap_scenario(5'h0A);
    // walking one covers both strobe groups, every request code back to back
    for (int i = 0; i < 33; i++) begin
      xfer(33'h1 << i, 5'(i), ~(33'h1 << i), ~5'(i), 1'b0);
    end
    mask_scenario(1'b1);
    mask_scenario(1'b0);
    stall_scenario(1'b0);
    stall_scenario(1'b1);
    close_out();
  end
endmodule
